// ===== dv/fwdm_chk_sva.sv
// checker for the mapper's image layout and word counts
`timescale 1ns/1ps
`default_nettype none
`include "fwdm_map.svh"
module fwdm_chk (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [1:0] fmt_sel_in,
  input wire logic [1:0] ord_sel_in,
  input wire logic [1:0] slot_cnt_in,
  input wire logic share_en_in,
  input wire logic [3:0] slot_upd_in,
  input wire logic [127:0] slot_disp_in,
  input wire logic [127:0] slot_float_in,
  input wire logic [431:0] dev_image_out,
  input wire logic [4:0] in_words_out,
  input wire logic [4:0] out_words_out
);
  // ==========
  // helpers
  logic flt;
  logic [4:0] spw;
  logic [4:0] exp_in;
  logic [4:0] exp_out;
  logic [4:0] quiet_r;
  logic go;
  // expected word counts and a clean slot-0 update
  always_comb
  begin
    flt = fmt_sel_in == `FWDM_FMT_FLT;
    spw = flt ? `FWDM_WPS_FLT : `FWDM_WPS_INT;
    exp_out = spw * ({3'h0, slot_cnt_in} + 5'h01);
    exp_in = exp_out + (share_en_in ? (flt ? 5'h0B : 5'h0C) : 5'h00);
    exp_out = exp_out + (share_en_in ? 5'h0F : 5'h00);
    go = quiet_r == 5'h1F && slot_upd_in == 4'h1;
  end
  // cycles since the last slot pulse, so queued slots cannot interfere
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in || slot_upd_in != 4'h0)
      quiet_r <= 5'h00;
    else if (quiet_r != 5'h1F)
      quiet_r <= quiet_r + 5'h01;
  end
  function automatic logic [15:0] fwdm_bs(input logic [15:0] v);
    return {v[7:0], v[15:8]};
  endfunction : fwdm_bs
  // first and second float words for each ordering
  function automatic logic [31:0] fwdm_fo(input logic [1:0] o, input logic [31:0] v);
    case (o)
      `FWDM_ORD_WORD: return {v[15:0], v[31:16]};
      `FWDM_ORD_BYTE: return {fwdm_bs(v[15:0]), fwdm_bs(v[31:16])};
      `FWDM_ORD_STD: return v;
      default: return {fwdm_bs(v[31:16]), fwdm_bs(v[15:0])};
    endcase
  endfunction : fwdm_fo
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);
  // ==========
  // assertions
  a_reset_clears_image: assert property (disable iff (1'b0)
    !rst_n_in |=> dev_image_out == '0 && in_words_out == 5'h00)
    else $error("image not cleared by reset");
  a_in_words_count: assert property (
    $past(rst_n_in) |-> in_words_out == $past(exp_in))
    else $error("input word count wrong");
  a_out_words_count: assert property (
    $past(rst_n_in) |-> out_words_out == $past(exp_out))
    else $error("output word count wrong");
  a_idle_words_zero: assert property (
    $stable(in_words_out) |-> (dev_image_out >> {in_words_out, 4'h0}) == '0)
    else $error("word beyond count not zero");
  a_int_word_order: assert property (
    go && fmt_sel_in == `FWDM_FMT_INT |-> ##[1:8] dev_image_out[15:0] ==
    (^ord_sel_in ? fwdm_bs(slot_disp_in[15:0]) : slot_disp_in[15:0]))
    else $error("integer weight word wrong");
  a_float_word_order: assert property (
    go && flt |-> ##[1:8] {dev_image_out[31:16], dev_image_out[47:32]} ==
    fwdm_fo(ord_sel_in, slot_float_in[31:0]))
    else $error("float weight words wrong");
  a_head_flips: assert property (
    go && fmt_sel_in == `FWDM_FMT_INT |-> ##[1:8] $changed(dev_image_out[23]))
    else $error("head polarity did not flip");
  a_tail_after_head: assert property (
    $changed(dev_image_out[23]) && fmt_sel_in == `FWDM_FMT_INT && quiet_r < 5'h10 &&
    dev_image_out[31] != dev_image_out[23] |->
    !$changed(dev_image_out[31]) ##[1:2]
    ($changed(dev_image_out[31]) && dev_image_out[31] == dev_image_out[23]))
    else $error("tail bit not written after head");
endmodule : fwdm_chk
bind fwdm_mapper fwdm_chk u_chk (
  .mclk_in(mclk_in),
  .rst_n_in(rst_n_in),
  .fmt_sel_in(fmt_sel_in),
  .ord_sel_in(ord_sel_in),
  .slot_cnt_in(slot_cnt_in),
  .share_en_in(share_en_in),
  .slot_upd_in(slot_upd_in),
  .slot_disp_in(slot_disp_in),
  .slot_float_in(slot_float_in),
  .dev_image_out(dev_image_out),
  .in_words_out(in_words_out),
  .out_words_out(out_words_out)
);
`default_nettype wire

// ===== dv/fwdm_ctl_model.sv
// controller model: drives the output image, screens torn reads
`timescale 1ns/1ps
`default_nettype none
`include "fwdm_map.svh"
module fwdm_ctl_model (
  input wire logic mclk_in,
  input wire logic [`FWDM_IN_WORDS*`FWDM_WORD_W-1:0] dev_image_in,
  output logic [`FWDM_OUT_WORDS*`FWDM_WORD_W-1:0] ctl_image_out,
  output logic [15:0] torn_out,
  output logic resync_out
);
  logic [15:0] torn_r = 16'h0000;
  logic [3:0] run_r = 4'h0;
  initial ctl_image_out = '0;
  assign torn_out = torn_r;
  assign resync_out = run_r[3];
  // ==========
  // reads are counted as torn unless bits 31 and 23 agree, slot 0's integrity bits in every format but float
  always @(posedge mclk_in)
  begin
    if (dev_image_in[31] != dev_image_in[23])
    begin
      torn_r <= torn_r + 16'h0001;
      run_r <= run_r + {3'h0, run_r != 4'hF};
    end
    else
      run_r <= 4'h0;
  end
  // ==========
  // fields are loaded under null when nul is set (else with the command), then the command is set
  task automatic sd_req(input int b, input logic [15:0] cmd, input logic str,
                        input logic [47:0] nm, input logic nul);
    @(posedge mclk_in);
    ctl_image_out[16*b +: 16] <= nul ? `FWDM_CMD_NULL : cmd;
    ctl_image_out[16*b+16 +: 16] <= {15'h0000, str};
    ctl_image_out[16*b+32 +: 48] <= {nm[15:0], nm[31:16], nm[47:32]};
    ctl_image_out[16*b+80 +: 160] <= 160'hABCD;
    repeat (4) @(posedge mclk_in);
    ctl_image_out[16*b +: 16] <= cmd;
    repeat (8) @(posedge mclk_in);
  endtask : sd_req
endmodule : fwdm_ctl_model
`default_nettype wire

// ===== dv/tb.sv
// self-checking bench for the weight data mapper
`timescale 1ns/1ps
`default_nettype none
`include "fwdm_map.svh"
module tb;
  typedef struct {logic [1:0] f; logic [1:0] o; logic [31:0] d;
    logic [15:0] i; logic [31:0] x;} fwdm_row_t;
  typedef struct {logic [15:0] c; logic s; logic [47:0] n; logic nl;
    logic [15:0] st; logic [15:0] fd;} fwdm_sd_t;
  localparam logic [47:0] nm0 = 48'h763030303030;
  localparam logic [47:0] nm1 = 48'h763030303031;
  localparam logic [47:0] nm2 = 48'h763030303032;
  localparam logic [47:0] nm9 = 48'h763030303039;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [1:0] fmt = 2'h0;
  logic [1:0] ord = 2'h0;
  logic [1:0] cnt = 2'h0;
  logic share = 1'b0;
  logic [3:0] upd = 4'h0;
  logic [127:0] disp = '0;
  logic [127:0] flt = '0;
  logic [63:0] incr = '0;
  logic [59:0] resp = {4{15'h1234}};
  logic [55:0] stat = {4{14'h2A55}};
  logic [495:0] ctl;
  logic [431:0] img;
  logic [4:0] inw;
  logic [4:0] outw;
  logic [15:0] torn;
  logic [15:0] torn0 = 16'h0000;
  int failures = 0;
  int num_checks = 0;
  int cyc = 0;
  fwdm_row_t rows [14] = '{
    '{2'h0, 2'h0, 32'h54B, 16'h0, 32'h54B0000}, '{2'h0, 2'h1, 32'h54B, 16'h0, 32'h4B050000},
    '{2'h0, 2'h2, 32'h54B, 16'h0, 32'h4B050000}, '{2'h0, 2'h3, 32'h54B, 16'h0, 32'h54B0000},
    '{2'h3, 2'h0, 32'h54B, 16'h0, 32'h54B0000}, '{2'h0, 2'h0, 32'hC350, 16'h0, 32'hC3500000},
    '{2'h0, 2'h0, 32'hFFFFFF38, 16'h0, 32'hFF380000}, '{2'h1, 2'h0, 32'h1428, 16'hA, 32'h2040000},
    '{2'h1, 2'h0, 32'hFFFFFF38, 16'hA, 32'hFFEC0000}, '{2'h1, 2'h1, 32'h61A8, 16'h1, 32'hA8610000},
    '{2'h2, 2'h0, 32'h44A96000, 16'h0, 32'h600044A9}, '{2'h2, 2'h1, 32'h44A96000, 16'h0, 32'h60A944},
    '{2'h2, 2'h2, 32'h44A96000, 16'h0, 32'h44A96000}, '{2'h2, 2'h3, 32'h44A96000, 16'h0, 32'hA9440060}};
  fwdm_sd_t sdr [9] = '{
    '{16'h2, 1'b1, nm2, 1'b1, 16'h1, 16'h0}, '{16'h1, 1'b0, nm2, 1'b1, 16'h1, 16'hABCD},
    '{16'h1, 1'b0, nm9, 1'b0, 16'h1, 16'hABCD}, '{16'h2, 1'b1, nm0, 1'b1, 16'h3, 16'h0},
    '{16'h2, 1'b0, nm2, 1'b1, 16'h3, 16'h0}, '{16'h2, 1'b0, nm1, 1'b1, 16'h4, 16'h0},
    '{16'h1, 1'b0, nm9, 1'b1, 16'h2, 16'h0}, '{16'h5, 1'b0, nm2, 1'b1, 16'h3, 16'h0},
    '{16'h0, 1'b0, nm2, 1'b1, 16'h0, 16'h0}};
  fwdm_mapper u_dut (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .fmt_sel_in(fmt),
    .ord_sel_in(ord),
    .slot_cnt_in(cnt),
    .share_en_in(share),
    .slot_upd_in(upd),
    .slot_disp_in(disp),
    .slot_incr_in(incr),
    .slot_float_in(flt),
    .slot_resp_in(resp),
    .slot_stat_in(stat),
    .ctl_image_in(ctl),
    .dev_image_out(img),
    .in_words_out(inw),
    .out_words_out(outw)
  );
  fwdm_ctl_model u_ctl (
    .mclk_in(mclk_in),
    .dev_image_in(img),
    .ctl_image_out(ctl),
    .torn_out(torn),
    .resync_out()
  );
  // ==========
  // clock, timeout and helpers
  always #12.5 mclk_in = ~mclk_in;
  always @(posedge mclk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      failures++;
      results();
    end
  end
  function automatic logic [15:0] w(input int k);
    return img[16*k +: 16];
  endfunction : w
  task automatic check(input string nm, input logic [31:0] want, input logic [31:0] got);
    num_checks++;
    if (got !== want)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, want, got);
    end
  endtask : check
  // slot pulse after settling, then a long quiet spell
  task automatic pulse(input logic [3:0] m);
    repeat (4) @(posedge mclk_in);
    upd <= m;
    @(posedge mclk_in);
    upd <= 4'h0;
    repeat (40) @(posedge mclk_in);
  endtask : pulse
  task automatic results();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results
  // ==========
  // main sequence
  initial
  begin
    repeat (5) @(posedge mclk_in);
    check("reset image", 32'h1, {31'h0, img === '0});
    rst_n_in <= 1'b1;
    $display("reset test done");
    foreach (rows[n])
    begin
      fmt <= rows[n].f;
      ord <= rows[n].o;
      disp[31:0] <= rows[n].d;
      flt[31:0] <= rows[n].d;
      incr[15:0] <= rows[n].i;
      pulse(4'h1);
      if (rows[n].f == `FWDM_FMT_FLT)
      begin
        check("float", rows[n].x, {w(1), w(2)});
        check("float integrity", {31'h0, img[15]}, {31'h0, img[63]});
        check("resp", 32'h1234, w(0) & 16'h7FFF);
        check("in words", 32'h4, inw);
      end
      else
      begin
        check("weight", rows[n].x[31:16], w(0));
        check("integrity", {31'h0, img[23]}, {31'h0, img[31]});
        check("status", 32'h5455, w(1) & 16'h7F7F);
        check("in words", 32'h2, inw);
      end
      $display("format row %0d done", n);
    end
    fmt <= `FWDM_FMT_INT;
    ord <= `FWDM_ORD_WORD;
    cnt <= 2'h1;
    disp <= {32'h4, 32'h3, 32'h2, 32'h1};
    pulse(4'hF);
    check("slot 1", 32'h2, w(2));
    check("slot 3 unused", 32'h0, w(6));
    cnt <= 2'h3;
    share <= 1'b1;
    torn0 = torn;
    pulse(4'hF);
    check("torn cycles", 32'h2, {16'h0, torn - torn0});
    check("slot 3", 32'h4, w(6));
    check("in words", 32'h14, inw);
    check("out words", 32'h17, outw);
    fmt <= `FWDM_FMT_FLT;
    pulse(4'h0);
    check("in words", 32'h1B, inw);
    check("out words", 32'h1F, outw);
    $display("slot count test done");
    fmt <= `FWDM_FMT_INT;
    cnt <= 2'h0;
    foreach (sdr[n])
    begin
      u_ctl.sd_req(2, sdr[n].c, sdr[n].s, sdr[n].n, sdr[n].nl);
      check("sd status", sdr[n].st, w(3));
      check("sd field", sdr[n].fd, w(4));
    end
    $display("shared data test done");
    share <= 1'b0;
    repeat (4) @(posedge mclk_in);
    check("in words", 32'h2, inw);
    check("sd status gone", 32'h0, w(3));
    check("torn reads", 32'h1, {31'h0, torn != 16'h0});
    rst_n_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    check("mid reset", 32'h1, {31'h0, img === '0 && inw === 5'h00});
    rst_n_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    check("words after reset", 32'h2, inw);
    $display("mid-run reset test done");
    results();
  end
endmodule : tb
`default_nettype wire

// ===== hdl/fwdm_mapper.sv
// cyclic process-data image formatter for weighing slots and shared data
`timescale 1ns/1ps
`default_nettype none
`include "fwdm_map.svh"
// Summary of operation
// R1: integer format sends signed 16-bit weight
// R2: division format sends weight over increment
// R3: integer or division slot: two words each way
// R4: float slot: four words each way
// R5: float values are 32-bit single precision
// R6: overflow past 32767 wraps, no saturation
// R7: only float keeps decimal point
// R8: four selectable byte and word orderings
// R9: integer word ordering per table
// R10: float word ordering per table
// R11: integrity bits at slot start and end; integer and division slots put both in word 1, bits 7 and 15
// R12: controller drops reads with mismatched bits
// R13: controller reissues command after repeated mismatches; the controller model only raises resync_out after 8 in a row
// R14: controller supplies command, name, write value
// R15: read field filled only after read
// R16: shared-data status codes zero to four
// R17: variables self-typed, type clashes refused
// R18: act once per new command value
// R19: controller alternates null and read
// R20: shared fields present only when enabled
// R21: toggle polarity, head before, tail after
// R22: float halves ordered by chosen ordering
module fwdm_mapper (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [1:0] fmt_sel_in,
  input wire logic [1:0] ord_sel_in,
  input wire logic [1:0] slot_cnt_in,
  input wire logic share_en_in,
  input wire logic [`FWDM_SLOTS-1:0] slot_upd_in,
  input wire logic [`FWDM_SLOTS*32-1:0] slot_disp_in,
  input wire logic [`FWDM_SLOTS*16-1:0] slot_incr_in,
  input wire logic [`FWDM_SLOTS*32-1:0] slot_float_in,
  input wire logic [`FWDM_SLOTS*15-1:0] slot_resp_in,
  input wire logic [`FWDM_SLOTS*14-1:0] slot_stat_in,
  input wire logic [`FWDM_OUT_WORDS*`FWDM_WORD_W-1:0] ctl_image_in,
  output logic [`FWDM_IN_WORDS*`FWDM_WORD_W-1:0] dev_image_out,
  output logic [4:0] in_words_out,
  output logic [4:0] out_words_out
);
  // =====================================================================
  // helpers
  function automatic logic [15:0] fwdm_bswap(input logic [15:0] w);
    return {w[7:0], w[15:8]};
  endfunction : fwdm_bswap

  function automatic logic [15:0] fwdm_word(input logic [`FWDM_OUT_WORDS*16-1:0] img,
                                            input logic [4:0] idx);
    return img[{idx, 4'h0} +: 16];
  endfunction : fwdm_word

  fwdm_sd_if sd_bus ();
  fwdm_sdv_store u_store (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .sd(sd_bus.store)
  );

  logic is_flt;
  logic [4:0] wps;
  logic [4:0] slot_words;
  logic [4:0] pad;
  assign is_flt = (fmt_sel_in == `FWDM_FMT_FLT);
  // words per slot by format [R3] [R4]
  assign wps = is_flt ? `FWDM_WPS_FLT : `FWDM_WPS_INT; // [R3] [R4]
  assign slot_words = 5'(wps * ({3'h0, slot_cnt_in} + 5'h01));
  assign pad = is_flt ? 5'h00 : 5'h01;

  // =====================================================================
  // slot update sequencer
  fwdm_pkg::fwdm_slot_st_t slot_st_r;
  logic [1:0] cur_r;
  logic [`FWDM_SLOTS-1:0] pend_r;
  logic [`FWDM_SLOTS-1:0] pol_r;
  logic [`FWDM_SLOTS-1:0] active;
  logic [`FWDM_SLOTS-1:0] clr;
  logic [15:0] slot_img_r [0:15];
  logic any_pend;
  logic [1:0] pick;

  // slots beyond the configured count never update
  always_comb
  begin
    any_pend = 1'b0;
    pick = 2'h0;
    for (int k = `FWDM_SLOTS - 1; k >= 0; k--)
    begin
      active[k] = (2'(k) <= slot_cnt_in);
      if (pend_r[k] && active[k])
      begin
        any_pend = 1'b1;
        pick = 2'(k);
      end
    end
  end

  // new strobe wins over the clear of its pending bit
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
      pend_r <= '0;
    else
      pend_r <= ((pend_r & ~clr) | slot_upd_in) & active;
  end

  assign clr = (slot_st_r == fwdm_pkg::SLOT_HEAD) ? (4'h1 << cur_r) : 4'h0;

  // head, body, tail walk
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      slot_st_r <= fwdm_pkg::SLOT_IDLE;
      cur_r <= 2'h0;
    end
    else
    begin
      case (slot_st_r)
        fwdm_pkg::SLOT_IDLE:
        begin
          if (any_pend)
          begin
            cur_r <= pick;
            slot_st_r <= fwdm_pkg::SLOT_HEAD;
          end
        end
        fwdm_pkg::SLOT_HEAD: slot_st_r <= fwdm_pkg::SLOT_BODY;
        fwdm_pkg::SLOT_BODY: slot_st_r <= fwdm_pkg::SLOT_TAIL;
        default: slot_st_r <= fwdm_pkg::SLOT_IDLE;
      endcase
    end
  end

  // payload encoding of the current slot
  logic signed [31:0] disp;
  logic signed [31:0] quot;
  logic [15:0] incr;
  logic [15:0] wt_word;
  logic [31:0] flt_pair;
  logic [31:0] flt;
  logic [15:0] hi;
  logic [15:0] lo;
  logic [13:0] stat;
  logic [14:0] resp;
  always_comb
  begin
    disp = $signed(slot_disp_in[cur_r*32 +: 32]);
    incr = slot_incr_in[cur_r*16 +: 16];
    flt = slot_float_in[cur_r*32 +: 32]; // IEEE single, decimal point kept [R5] [R7]
    stat = slot_stat_in[cur_r*14 +: 14];
    resp = slot_resp_in[cur_r*15 +: 15];
    // display increments; zero increment passes the count through [R2]
    quot = (incr == 16'h0000) ? disp : disp / $signed({16'h0000, incr}); // [R2]
    // whole displayed digits, low 16 bits, wraps past 32767 [R1] [R6] [R7]
    wt_word = (fmt_sel_in == `FWDM_FMT_DIV) ? quot[15:0] : disp[15:0]; // [R1] [R6]
    if (ord_sel_in == `FWDM_ORD_BYTE || ord_sel_in == `FWDM_ORD_STD)
      wt_word = fwdm_bswap(wt_word); // [R8] [R9]
    hi = flt[31:16];
    lo = flt[15:0];
    // first word in [31:16], second in [15:0] [R10] [R22]
    case (ord_sel_in)
      `FWDM_ORD_WORD: flt_pair = {lo, hi}; // [R10]
      `FWDM_ORD_BYTE: flt_pair = {fwdm_bswap(lo), fwdm_bswap(hi)}; // [R10]
      `FWDM_ORD_STD: flt_pair = {hi, lo}; // [R22]
      default: flt_pair = {fwdm_bswap(hi), fwdm_bswap(lo)}; // [R8] [R22]
    endcase
  end

  // slot image: head bit, then payload, then tail bit [R11] [R21]
  int base;
  assign base = int'(cur_r) * int'(wps);
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      pol_r <= '0;
      for (int w = 0; w < 16; w++)
        slot_img_r[w] <= 16'h0000;
    end
    else
    begin
      case (slot_st_r)
        fwdm_pkg::SLOT_HEAD:
        begin
          pol_r[cur_r] <= ~pol_r[cur_r]; // [R21]
          if (is_flt)
            slot_img_r[base][`FWDM_IB_HI] <= ~pol_r[cur_r]; // [R11] [R21]
          else
            slot_img_r[base + 1][`FWDM_IB_LO] <= ~pol_r[cur_r]; // [R11] [R21]
        end
        fwdm_pkg::SLOT_BODY:
        begin
          if (is_flt)
          begin
            slot_img_r[base][14:0] <= resp;
            slot_img_r[base + 1] <= flt_pair[31:16]; // [R4] [R5]
            slot_img_r[base + 2] <= flt_pair[15:0];
            slot_img_r[base + 3][14:0] <= {1'b0, stat};
          end
          else
          begin
            slot_img_r[base] <= wt_word; // [R3]
            slot_img_r[base + 1][14:8] <= stat[13:7];
            slot_img_r[base + 1][6:0] <= stat[6:0];
          end
        end
        fwdm_pkg::SLOT_TAIL:
          slot_img_r[base + int'(wps) - 1][`FWDM_IB_HI] <= pol_r[cur_r]; // [R11] [R21]
        default: ;
      endcase
    end
  end

  // =====================================================================
  // shared-data exchange
  fwdm_pkg::fwdm_sd_st_t sd_st_r;
  logic [15:0] cmd;
  logic [15:0] cmd_prev_r;
  logic rd_r;
  logic req_r;
  logic wstr_r;
  logic [`FWDM_NAME_W-1:0] name_r;
  logic [`FWDM_VAL_W-1:0] wval_r;
  logic [15:0] sd_stat_r;
  logic [`FWDM_VAL_W-1:0] sd_rf_r;
  logic [`FWDM_NAME_W-1:0] name_in;
  logic [`FWDM_VAL_W-1:0] wval_in;
  logic [15:0] flags_in;

  assign cmd = fwdm_word(ctl_image_in, slot_words);
  // flags, name and write value words behind the command word
  always_comb
  begin
    flags_in = fwdm_word(ctl_image_in, 5'(slot_words + `FWDM_OFS_FLAGS));
    name_in = '0;
    wval_in = '0;
    for (int i = 0; i < 3; i++)
      name_in[(2 - i)*16 +: 16] = fwdm_word(ctl_image_in, 5'(slot_words + `FWDM_OFS_NAME + 5'(i)));
    for (int i = 0; i < `FWDM_SD_WORDS; i++)
      wval_in[i*16 +: 16] = fwdm_word(ctl_image_in, 5'(slot_words + `FWDM_OFS_WVAL + 5'(i)));
  end

  assign sd_bus.req = req_r;
  assign sd_bus.wr = !rd_r;
  assign sd_bus.wstr = wstr_r;
  assign sd_bus.name = name_r;
  assign sd_bus.wdata = wval_r;

  // one action for each new command value [R18] [R14]
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      sd_st_r <= fwdm_pkg::SD_IDLE;
      cmd_prev_r <= `FWDM_CMD_NULL;
      rd_r <= 1'b1;
      req_r <= 1'b0;
      wstr_r <= 1'b0;
      name_r <= '0;
      wval_r <= '0;
      sd_stat_r <= `FWDM_ST_NULL;
      sd_rf_r <= '0;
    end
    else
    begin
      req_r <= 1'b0;
      case (sd_st_r)
        fwdm_pkg::SD_IDLE:
        begin
          if (!share_en_in)
          begin
            cmd_prev_r <= `FWDM_CMD_NULL; // [R20]
            sd_stat_r <= `FWDM_ST_NULL;
            sd_rf_r <= '0;
          end
          else if (cmd != cmd_prev_r)
          begin
            cmd_prev_r <= cmd; // [R18]
            sd_rf_r <= '0;
            if (cmd == `FWDM_CMD_READ || cmd == `FWDM_CMD_WRITE)
            begin
              req_r <= 1'b1;
              rd_r <= (cmd == `FWDM_CMD_READ);
              name_r <= name_in; // [R14]
              wval_r <= wval_in;
              wstr_r <= flags_in[`FWDM_FLAG_STR]; // [R17]
              sd_st_r <= fwdm_pkg::SD_WAIT;
            end
            else if (cmd == `FWDM_CMD_NULL)
              sd_stat_r <= `FWDM_ST_NULL; // [R16]
            else
              sd_stat_r <= `FWDM_ST_BADCMD; // [R16]
          end
        end
        default:
        begin
          if (sd_bus.ack)
          begin
            sd_stat_r <= sd_bus.status; // [R16] [R17]
            if (rd_r && sd_bus.status == `FWDM_ST_OK)
              sd_rf_r <= sd_bus.rdata; // [R15]
            sd_st_r <= fwdm_pkg::SD_IDLE;
          end
        end
      endcase
    end
  end

  // =====================================================================
  // image assembly and word counts
  logic [15:0] img_nxt [0:`FWDM_IN_WORDS-1];
  int spos;
  always_comb
  begin
    spos = int'(slot_words) + int'(pad);
    for (int w = 0; w < `FWDM_IN_WORDS; w++)
      img_nxt[w] = 16'h0000;
    for (int w = 0; w < 16; w++)
      if (5'(w) < slot_words)
        img_nxt[w] = slot_img_r[w];
    if (share_en_in)
    begin
      img_nxt[spos] = sd_stat_r; // [R20]
      for (int i = 0; i < `FWDM_SD_WORDS; i++)
        img_nxt[spos + 1 + i] = sd_rf_r[i*16 +: 16]; // [R15]
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      dev_image_out <= '0;
      in_words_out <= 5'h00;
      out_words_out <= 5'h00;
    end
    else
    begin
      for (int w = 0; w < `FWDM_IN_WORDS; w++)
        dev_image_out[w*16 +: 16] <= img_nxt[w];
      in_words_out <= 5'(slot_words + (share_en_in ? 5'(pad + `FWDM_SD_IN_LEN) : 5'h00)); // [R20]
      out_words_out <= 5'(slot_words + (share_en_in ? `FWDM_SD_OUT_LEN : 5'h00)); // [R3] [R4]
    end
  end
endmodule : fwdm_mapper
`default_nettype wire

// ===== hdl/fwdm_sdv_store.sv
// shared-data variable store with typing and write protection
`timescale 1ns/1ps
`default_nettype none
`include "fwdm_map.svh"
module fwdm_sdv_store #(
  parameter logic [`FWDM_SDV_N*`FWDM_NAME_W-1:0] NAMES = {
    48'h763030303033, 48'h763030303032, 48'h763030303031, 48'h763030303030},
  parameter logic [`FWDM_SDV_N-1:0] IS_FLOAT = 4'h3,
  parameter logic [`FWDM_SDV_N-1:0] WPROT = 4'h2
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  fwdm_sd_if.store sd
);
  logic [`FWDM_VAL_W-1:0] val_r [0:`FWDM_SDV_N-1];
  logic hit;
  logic [1:0] idx;

  // =====================================================================
  // name lookup
  always_comb
  begin
    hit = 1'b0;
    idx = 2'h0;
    for (int i = 0; i < `FWDM_SDV_N; i++)
    begin
      if (!hit && sd.name == NAMES[i*`FWDM_NAME_W +: `FWDM_NAME_W])
      begin
        hit = 1'b1;
        idx = 2'(i);
      end
    end
  end

  // =====================================================================
  // answer one cycle after each request
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      sd.ack <= 1'b0;
      sd.status <= `FWDM_ST_NULL;
      sd.rdata <= '0;
      for (int i = 0; i < `FWDM_SDV_N; i++)
        val_r[i] <= '0;
    end
    else
    begin
      sd.ack <= sd.req;
      if (sd.req)
      begin
        sd.rdata <= '0;
        if (!hit)
          sd.status <= `FWDM_ST_BADNAME;
        else if (!sd.wr)
        begin
          sd.status <= `FWDM_ST_OK;
          sd.rdata <= val_r[idx];
        end
        else if (WPROT[idx])
          sd.status <= `FWDM_ST_WPROT; // [R16]
        else if (sd.wstr == IS_FLOAT[idx])
          sd.status <= `FWDM_ST_BADCMD; // type clash refused [R17]
        else
        begin
          sd.status <= `FWDM_ST_OK;
          val_r[idx] <= sd.wdata;
        end
      end
    end
  end
endmodule : fwdm_sdv_store
`default_nettype wire

// ===== include/fwdm_map.svh
// constant map for the fieldbus weight data mapper
`ifndef FWDM_MAP_SVH
`define FWDM_MAP_SVH

// =====================================================================
// sizes
`define FWDM_WORD_W 16
`define FWDM_SLOTS 4
`define FWDM_IN_WORDS 27
`define FWDM_OUT_WORDS 31
`define FWDM_SD_WORDS 10
`define FWDM_NAME_W 48
`define FWDM_VAL_W 160
`define FWDM_SDV_N 4

// =====================================================================
// data formats and orderings
`define FWDM_FMT_INT 2'h0
`define FWDM_FMT_DIV 2'h1
`define FWDM_FMT_FLT 2'h2
`define FWDM_ORD_WORD 2'h0
`define FWDM_ORD_BYTE 2'h1
`define FWDM_ORD_STD 2'h2
`define FWDM_ORD_DWORD 2'h3
`define FWDM_WPS_INT 5'h02
`define FWDM_WPS_FLT 5'h04

// =====================================================================
// shared-data commands and status codes
`define FWDM_CMD_NULL 16'h0000
`define FWDM_CMD_READ 16'h0001
`define FWDM_CMD_WRITE 16'h0002
`define FWDM_ST_NULL 16'h0000
`define FWDM_ST_OK 16'h0001
`define FWDM_ST_BADNAME 16'h0002
`define FWDM_ST_BADCMD 16'h0003
`define FWDM_ST_WPROT 16'h0004

// =====================================================================
// shared-data field offsets from the end of the slot area
`define FWDM_OFS_FLAGS 5'h01
`define FWDM_OFS_NAME 5'h02
`define FWDM_OFS_WVAL 5'h05
`define FWDM_SD_OUT_LEN 5'h0F
`define FWDM_SD_IN_LEN 5'h0B
`define FWDM_FLAG_STR 0

// =====================================================================
// integrity bit positions
`define FWDM_IB_HI 15
`define FWDM_IB_LO 7

`endif

// ===== include/fwdm_pkg.sv
// types for the fieldbus weight data mapper
package fwdm_pkg;
  typedef enum logic [1:0] {SLOT_IDLE, SLOT_HEAD, SLOT_BODY, SLOT_TAIL} fwdm_slot_st_t;
  typedef enum logic {SD_IDLE, SD_WAIT} fwdm_sd_st_t;
endpackage : fwdm_pkg

// ===== include/fwdm_sd_if.sv
// shared-data request and answer between mapper and variable store
`timescale 1ns/1ps
`default_nettype none
`include "fwdm_map.svh"
interface fwdm_sd_if;
  logic req;
  logic wr;
  logic wstr;
  logic [`FWDM_NAME_W-1:0] name;
  logic [`FWDM_VAL_W-1:0] wdata;
  logic ack;
  logic [`FWDM_WORD_W-1:0] status;
  logic [`FWDM_VAL_W-1:0] rdata;
  modport mapper (output req, wr, wstr, name, wdata, input ack, status, rdata);
  modport store (input req, wr, wstr, name, wdata, output ack, status, rdata);
endinterface : fwdm_sd_if
`default_nettype wire
